/* File: core/sdram_geom_pkg.sv */
// Purpose: Constants and tables for the SDRAM geometry and clock-enable
//          configuration block.
// Assumes: One word per register on a 32-bit AXI4-Lite bus.
// Notes:   Tables are indexed by the two-bit density code.
package sdram_geom_pkg;
	// ==========================================================
	// Register map
	// ==========================================================
	// Printed offsets are register indices; byte address is index * 4
	localparam logic [13:0] GEOM_IDX = 14'h1c06;
	localparam logic [13:0] BUS_IDX = 14'h1c02;
	localparam int ADDR_W = 16;

	localparam int DYN_CKE_BIT = 14;
	localparam int AUTO_PRE_BIT = 3;
	localparam int SIZE_LSB = 1;
	localparam int BUS_LSB = 1;

	localparam logic [15:0] GEOM_RESET = 16'hc010;
	// Only bits 15,14,5..0 exist; the rest read as zero
	localparam logic [15:0] GEOM_MASK = 16'hc03f;
	localparam logic [1:0] BUS_RESET = 2'h1;

	localparam logic [1:0] BUS_16 = 2'h1;
	localparam logic [1:0] BUS_32 = 2'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Geometry tables, index = density code (128,256,512,64 Mbit)
	// ==========================================================
	localparam logic [3:0] COL16_TBL [4] = '{4'h9, 4'h9, 4'ha, 4'h8};
	localparam logic [3:0] ROW16_TBL [4] = '{4'hc, 4'hd, 4'hd, 4'hc};
	localparam logic [3:0] COL32_TBL [4] = '{4'h8, 4'h9, 4'h9, 4'h8};
	localparam logic [3:0] ROW32_TBL [4] = '{4'hc, 4'hc, 4'hd, 4'hb};
	localparam logic [1:0] BANK_W = 2'h2;
	localparam logic [1:0] SIZE_RESET = 2'h0;
endpackage : sdram_geom_pkg

/* File: core/geom_if.sv */
// Purpose: Carries density and bus width to the decoder and widths back.
// Assumes: Same clock domain on both sides.
// Notes:   Purely combinational signals.
interface geom_if;
	logic [1:0] size;
	logic [1:0] bus_sel;
	logic [3:0] col_w;
	logic [3:0] row_w;
	logic [1:0] bank_w;
	logic bus_reserved;

	modport ctrl (output size, output bus_sel, input col_w, input row_w,
		input bank_w, input bus_reserved);
	modport dec (input size, input bus_sel, output col_w, output row_w,
		output bank_w, output bus_reserved);
endinterface : geom_if

/* File: core/sdram_geom_decode.sv */
// Purpose: Maps density code and bus width to address widths.
// Assumes: Inputs come from registers on the same clock.
// Notes:   Reserved bus widths fall back to the 16-bit set.
module sdram_geom_decode (
	// Geometry link
	geom_if.dec g
);
	logic wide;

	always_comb
	begin
		wide = (g.bus_sel == sdram_geom_pkg::BUS_32);
		g.bus_reserved = (g.bus_sel != sdram_geom_pkg::BUS_16) && !wide;
		if (wide)
		begin
			g.col_w = sdram_geom_pkg::COL32_TBL[g.size];
			g.row_w = sdram_geom_pkg::ROW32_TBL[g.size];
		end
		else
		begin
			g.col_w = sdram_geom_pkg::COL16_TBL[g.size];
			g.row_w = sdram_geom_pkg::ROW16_TBL[g.size];
		end
		g.bank_w = sdram_geom_pkg::BANK_W;
	end
endmodule : sdram_geom_decode

/* File: core/sdram_geometry_cke_config.sv */
// Purpose: Geometry / clock-enable configuration register with an
//          AXI4-Lite slave, driving the SDRAM clock enable and widths.
// Assumes: BUS_ACTIVE comes from controller logic on REF_CLK.
// Notes:   Outputs are registered except AWREADY, WREADY and ARREADY, which are gated from state; settings act one cycle late.
module sdram_geometry_cke_config (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// AXI4-Lite write address
	input wire logic [15:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// AXI4-Lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read address
	input wire logic [15:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// AXI4-Lite read data
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Controller side
	input wire logic BUS_ACTIVE,
	output logic SDRAM_CLK_EN_PIN,
	output logic AUTO_PRECHARGE,
	output logic [3:0] COL_WIDTH,
	output logic [3:0] ROW_WIDTH,
	output logic [1:0] BANK_WIDTH,
	output logic WIDTH_RESERVED
);
	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [15:0] geom;
		logic [1:0] bus_sel;
		logic aw_got;
		logic [13:0] aw_idx;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic cke;
		logic apre;
		logic [3:0] col;
		logic [3:0] row;
		logic [1:0] bank;
		logic wres;
	} state_type;

	localparam state_type RESET_STATE = '{
		geom: sdram_geom_pkg::GEOM_RESET,
		bus_sel: sdram_geom_pkg::BUS_RESET,
		cke: 1'b1,
		col: sdram_geom_pkg::COL16_TBL[sdram_geom_pkg::SIZE_RESET],
		row: sdram_geom_pkg::ROW16_TBL[sdram_geom_pkg::SIZE_RESET],
		bank: sdram_geom_pkg::BANK_W,
		default: '0
	};

	state_type state_ff;
	state_type nxt_state;
	geom_if g ();

	// Precharge select, shared by the next-state logic and the checks
	logic apre_bit;
	assign apre_bit = state_ff.geom[sdram_geom_pkg::AUTO_PRE_BIT];

	// ==========================================================
	// Geometry decoder
	// ==========================================================
	assign g.size = state_ff.geom[sdram_geom_pkg::SIZE_LSB +: 2];
	assign g.bus_sel = state_ff.bus_sel;

	sdram_geom_decode u_decode (
		.g(g)
	);

	// ==========================================================
	// Bus handshakes
	// ==========================================================
	// Holding off new writes while a response waits keeps one in flight
	assign AWREADY = !state_ff.aw_got && !state_ff.bvalid;
	assign WREADY = !state_ff.w_got && !state_ff.bvalid;
	assign ARREADY = !state_ff.rvalid;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] lane;
		lane = {{8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~lane) | (data[15:0] & lane);
	endfunction : merge

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		logic [13:0] ridx;
		ridx = ARADDR[15:2];
		nxt_state = state_ff;

		if (AWVALID && AWREADY)
		begin
			nxt_state.aw_got = 1'b1;
			nxt_state.aw_idx = AWADDR[15:2];
		end
		if (WVALID && WREADY)
		begin
			nxt_state.w_got = 1'b1;
			nxt_state.wdata = WDATA;
			nxt_state.wstrb = WSTRB;
		end

		// Commit once both halves of a write are held
		if (state_ff.aw_got && state_ff.w_got)
		begin
			nxt_state.aw_got = 1'b0;
			nxt_state.w_got = 1'b0;
			nxt_state.bvalid = 1'b1;
			nxt_state.bresp = sdram_geom_pkg::RESP_OKAY;
			if (state_ff.aw_idx == sdram_geom_pkg::GEOM_IDX)
			begin
				nxt_state.geom = merge(state_ff.geom, state_ff.wdata,
					state_ff.wstrb) & sdram_geom_pkg::GEOM_MASK;
			end
			else if (state_ff.aw_idx == sdram_geom_pkg::BUS_IDX)
			begin
				if (state_ff.wstrb[0])
				begin
					nxt_state.bus_sel =
						state_ff.wdata[sdram_geom_pkg::BUS_LSB +: 2];
				end
			end
			else
			begin
				nxt_state.bresp = sdram_geom_pkg::RESP_SLVERR;
			end
		end
		else if (BVALID && BREADY)
		begin
			nxt_state.bvalid = 1'b0;
		end

		if (ARVALID && ARREADY)
		begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp = sdram_geom_pkg::RESP_OKAY;
			nxt_state.rdata = '0;
			if (ridx == sdram_geom_pkg::GEOM_IDX)
			begin
				nxt_state.rdata[15:0] = state_ff.geom;
			end
			else if (ridx == sdram_geom_pkg::BUS_IDX)
			begin
				nxt_state.rdata[sdram_geom_pkg::BUS_LSB +: 2] =
					state_ff.bus_sel;
			end
			else
			begin
				nxt_state.rresp = sdram_geom_pkg::RESP_SLVERR;
			end
		end
		else if (RVALID && RREADY)
		begin
			nxt_state.rvalid = 1'b0;
		end

		// Clock enable: static high, or follow the bus when dynamic
		if (state_ff.geom[sdram_geom_pkg::DYN_CKE_BIT])
		begin
			nxt_state.cke = BUS_ACTIVE;
		end
		else
		begin
			nxt_state.cke = 1'b1;
		end
		nxt_state.apre = apre_bit;
		nxt_state.col = g.col_w;
		nxt_state.row = g.row_w;
		nxt_state.bank = g.bank_w;
		nxt_state.wres = g.bus_reserved;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			state_ff <= RESET_STATE;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign BVALID = state_ff.bvalid;
	assign BRESP = state_ff.bresp;
	assign RVALID = state_ff.rvalid;
	assign RRESP = state_ff.rresp;
	assign RDATA = state_ff.rdata;
	assign SDRAM_CLK_EN_PIN = state_ff.cke;
	assign AUTO_PRECHARGE = state_ff.apre;
	assign COL_WIDTH = state_ff.col;
	assign ROW_WIDTH = state_ff.row;
	assign BANK_WIDTH = state_ff.bank;
	assign WIDTH_RESERVED = state_ff.wres;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	logic dyn;
	logic [1:0] size;
	logic wide;
	logic narrow;
	assign dyn = state_ff.geom[sdram_geom_pkg::DYN_CKE_BIT];
	assign size = state_ff.geom[sdram_geom_pkg::SIZE_LSB +: 2];
	assign wide = (state_ff.bus_sel == sdram_geom_pkg::BUS_32);
	// Reserved bus widths fall back to the 16-bit set
	assign narrow = !wide;

	sequence s_write_held;
		state_ff.aw_got && state_ff.w_got;
	endsequence

	sequence s_resp_out;
		BVALID && !AWREADY && !WREADY;
	endsequence

	sequence s_read_taken;
		ARVALID && ARREADY;
	endsequence

	sequence s_read_out;
		RVALID && !ARREADY;
	endsequence

	// Clock enable and precharge
	a_cke_static_high: assert property (
		!dyn |=> SDRAM_CLK_EN_PIN)
		else $error("clock enable dropped while static");

	a_cke_follows_bus: assert property (
		dyn |=> SDRAM_CLK_EN_PIN == $past(BUS_ACTIVE))
		else $error("clock enable does not follow bus state");

	a_precharge_off: assert property (
		!apre_bit |=> !AUTO_PRECHARGE)
		else $error("auto precharge on while disabled");

	a_precharge_on: assert property (
		apre_bit |=> AUTO_PRECHARGE)
		else $error("auto precharge off while enabled");

	// Address widths, 16-bit set
	a_size_64_narrow: assert property (
		size == 2'h3 && narrow
		|=> COL_WIDTH == 4'h8 && ROW_WIDTH == 4'hc)
		else $error("64 Mbit 16-bit widths wrong");

	a_size_128_narrow: assert property (
		size == 2'h0 && narrow
		|=> COL_WIDTH == 4'h9 && ROW_WIDTH == 4'hc)
		else $error("128 Mbit 16-bit widths wrong");

	a_size_256_narrow: assert property (
		size == 2'h1 && narrow
		|=> COL_WIDTH == 4'h9 && ROW_WIDTH == 4'hd)
		else $error("256 Mbit 16-bit widths wrong");

	a_widths_narrow: assert property (
		size == 2'h2 && narrow
		|=> COL_WIDTH == 4'ha && ROW_WIDTH == 4'hd
		&& BANK_WIDTH == 2'h2)
		else $error("512 Mbit 16-bit widths wrong");

	// Address widths, 32-bit set, and reserved-width flag
	a_widths_wide: assert property (
		size == 2'h3 && wide
		|=> COL_WIDTH == 4'h8 && ROW_WIDTH == 4'hb
		&& BANK_WIDTH == 2'h2)
		else $error("64 Mbit 32-bit widths wrong");

	a_size_128_wide: assert property (
		size == 2'h0 && wide
		|=> COL_WIDTH == 4'h8 && ROW_WIDTH == 4'hc)
		else $error("128 Mbit 32-bit widths wrong");

	a_bus_select: assert property (
		size == 2'h1 && wide
		|=> COL_WIDTH == 4'h9 && ROW_WIDTH == 4'hc && !WIDTH_RESERVED)
		else $error("32-bit set not selected");

	a_size_512_wide: assert property (
		size == 2'h2 && wide
		|=> COL_WIDTH == 4'h9 && ROW_WIDTH == 4'hd)
		else $error("512 Mbit 32-bit widths wrong");

	a_width_reserved: assert property (
		narrow && state_ff.bus_sel != sdram_geom_pkg::BUS_16
		|=> WIDTH_RESERVED)
		else $error("reserved bus width not flagged");

	// Reset values
	a_reset_bits: assert property (
		$fell(RST) |-> state_ff.geom[15] && !state_ff.geom[0]
		&& state_ff.geom[5:4] == 2'h1)
		else $error("reserved bits wrong after reset");

	a_reset_outs: assert property (
		$fell(RST) |-> SDRAM_CLK_EN_PIN && !AUTO_PRECHARGE
		&& COL_WIDTH == 4'h9 && ROW_WIDTH == 4'hc
		&& state_ff.bus_sel == sdram_geom_pkg::BUS_16
		&& !BVALID && !RVALID)
		else $error("outputs wrong after reset");

	// Handshakes
	a_write_answer: assert property (s_write_held |=> s_resp_out)
		else $error("write response missing");

	a_read_answer: assert property (s_read_taken |=> s_read_out)
		else $error("read data missing");

	a_read_geom: assert property (
		ARVALID && ARREADY && ARADDR[15:2] == sdram_geom_pkg::GEOM_IDX
		|=> RDATA == {16'h0000, $past(state_ff.geom)})
		else $error("register read data wrong");

	a_resp_taken: assert property (BVALID && BREADY |=> !BVALID)
		else $error("write response held after taken");

	a_data_taken: assert property (RVALID && RREADY |=> !RVALID)
		else $error("read data held after taken");
endmodule : sdram_geometry_cke_config

/* File: tb/sdram_far_model.sv */
// Purpose: Far-side SDRAM stand-in that reports the capacity its
//          geometry spans.
// Assumes: Widths arrive as decimal bit counts.
// Notes:   Data width is strapped by the bench like a real part.
module sdram_far_model (
	// Geometry from the controller
	input wire logic [3:0] col_w,
	input wire logic [3:0] row_w,
	input wire logic [1:0] bank_w,
	// Strap: part is 32 bits wide
	input wire logic wide,
	// Log2 of the capacity in bits
	output logic [5:0] cap_log2
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb
		cap_log2 = 6'(col_w) + 6'(row_w) + 6'(bank_w) + (wide ? 6'h5 : 6'h4);
endmodule : sdram_far_model

/* File: tb/tb_sdram_geometry_cke_config.sv */
// Purpose: Self-checking bench for the geometry / clock-enable register.
// Assumes: Responses come within a few cycles of each request.
// Notes:   Outputs lag a committed write, so checks wait two edges.
module tb_sdram_geometry_cke_config;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [1:0] bus; logic [1:0] code; logic ap;
		logic [3:0] col; logic [3:0] row;} row_type;
	localparam logic [15:0] GEOM_A = 16'h7018;
	localparam logic [15:0] BUS_A = 16'h7008;
	// Reserved widths 00 and 11 fall back to the 16-bit set
	row_type tbl [10] = '{'{2'h1, 2'h3, 1'h0, 4'h8, 4'hc},
		'{2'h1, 2'h0, 1'h1, 4'h9, 4'hc}, '{2'h1, 2'h1, 1'h0, 4'h9, 4'hd},
		'{2'h1, 2'h2, 1'h1, 4'ha, 4'hd}, '{2'h2, 2'h3, 1'h1, 4'h8, 4'hb},
		'{2'h2, 2'h0, 1'h0, 4'h8, 4'hc}, '{2'h2, 2'h1, 1'h1, 4'h9, 4'hc},
		'{2'h2, 2'h2, 1'h0, 4'h9, 4'hd}, '{2'h0, 2'h2, 1'h0, 4'ha, 4'hd},
		'{2'h3, 2'h1, 1'h1, 4'h9, 4'hd}};
	logic clk = 1'b0, rst = 1'b1, ba = 1'b0, wide = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [15:0] awaddr = 16'h0, araddr = 16'h0;
	logic [31:0] wdata = 32'h0, rdata, d, v;
	logic [3:0] wstrb = 4'hf, col, row;
	logic [1:0] bresp, rresp, bank, r;
	logic awready, wready, bvalid, arready, rvalid, cke, ap, wres;
	logic [5:0] cap;
	int err_total = 0, checks_done = 0;
	row_type t;
	always #10 clk = ~clk;
	sdram_geometry_cke_config sdram_geometry_cke_config_inst (.REF_CLK(clk),
		.RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .BUS_ACTIVE(ba),
		.SDRAM_CLK_EN_PIN(cke), .AUTO_PRECHARGE(ap), .COL_WIDTH(col),
		.ROW_WIDTH(row), .BANK_WIDTH(bank), .WIDTH_RESERVED(wres));
	sdram_far_model sdram_far_model_inst (.col_w(col), .row_w(row),
		.bank_w(bank), .wide(wide), .cap_log2(cap));
	// ==========================================================
	// Bus tasks and checks
	// ==========================================================
	task automatic wr(input logic [15:0] a, input logic [31:0] x,
		output logic [1:0] s);
		@(posedge clk);
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bready && bvalid) s = bresp;
			if (bready && bvalid) bready <= 1'b0;
		end while (awvalid | wvalid | bready);
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [31:0] x,
		output logic [1:0] s);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid) x = rdata;
			if (rready && rvalid) s = rresp;
			if (rready && rvalid) rready <= 1'b0;
		end while (arvalid | rready);
	endtask : rd
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic close_out();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	// ==========================================================
	// Sequence
	// ==========================================================
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({cke, ap, wres}, 3'h0, "reset flags");
		chk({bank, col, row}, 10'h29c, "reset widths");
		rd(GEOM_A, d, r);
		chk(d, 32'h0000c010, "geom reset");
		rd(BUS_A, d, r);
		chk(d, 32'h00000002, "width reset");
		for (int i = 0; i < 10; i++)
		begin
			t = tbl[i];
			wide <= (t.bus == 2'h2);
			wr(BUS_A, 32'(t.bus) << 1, r);
			v = 32'h0000c010 | (32'(t.code) << 1) | (32'(t.ap) << 3);
			wr(GEOM_A, v, r);
			chk(r, sdram_geom_pkg::RESP_OKAY, "write resp");
			repeat (2) @(posedge clk);
			#1;
			chk({ap, col, row}, {t.ap, t.col, t.row}, "geom");
			chk({bank, wres}, {2'h2, t.bus == 2'h0 || t.bus == 2'h3}, "bank");
			chk(cap, t.code == 2'h3 ? 6'h1a : 6'h1b + 6'(t.code), "cap");
			rd(GEOM_A, d, r);
			chk(d, v, "readback");
		end
		// Clock enable across both select settings and bus states
		for (int k = 0; k < 4; k++)
		begin
			wr(GEOM_A, k[1] ? 32'h0000c010 : 32'h00008010, r);
			@(posedge clk);
			ba <= k[0];
			repeat (2) @(posedge clk);
			#1;
			chk(cke, !k[1] || k[0], "clk enable");
		end
		wr(16'h7010, 32'h0000ffff, r);
		chk(r, sdram_geom_pkg::RESP_SLVERR, "unmapped wr");
		rd(16'h7010, d, r);
		chk(r, sdram_geom_pkg::RESP_SLVERR, "unmapped rd");
		chk(d, 32'h0, "unmapped data");
		rd(GEOM_A, d, r);
		chk(d, 32'h0000c010, "geom kept");
		// Low byte lane only: bits 15..8 must keep their value
		wstrb <= 4'h1;
		wr(GEOM_A, 32'h0000ff0e, r);
		wstrb <= 4'hf;
		rd(GEOM_A, d, r);
		chk(d, 32'h0000c00e, "byte lane");
		// Reset in mid-run must bring every default back
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk(cke, 1'b1, "rerun cke");
		chk({ap, wres, bank, col, row}, 11'h29c, "rerun outs");
		rd(GEOM_A, d, r);
		chk(d, 32'h0000c010, "rerun geom");
		rd(BUS_A, d, r);
		chk(d, 32'h00000002, "rerun width");
		close_out();
	end
	initial
	begin
		#200000;
		err_total++;
		close_out();
	end
endmodule : tb_sdram_geometry_cke_config
